// ---- design/mmsc_monitor.sv ----
// monitor-mode security check and command interpreter
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - indexed reads and writes step through memory
// - run command executes pull-high then return-interrupt
// - entry executes software interrupt then push-high
// - read stack pointer returns pointer plus one
// - stacked pc high at sp+5, low sp+6
// - bypass only when eight bytes match stored
// - after power-on wait for eight security bytes
// - bypass holds until next power-on reset
// - other resets skip security byte entry, keep bypass
// - mismatch: flash reads return invalid value
// - flash fetch while secured causes illegal reset
// - after power-on, break sent only after eight bytes arrive; other resets send it right after entry
// - good entry sets flag bit in ram
// - bulk erase makes security bytes read blank until next power-on reset; secured reads still return invalid value
module mmsc_monitor #(
   parameter logic [15:0] BIT_CYCLES = mmsc_pkg::MMSC_BIT_CYCLES,
   parameter logic [15:0] FLASH_LO = mmsc_pkg::MMSC_FLASH_LO
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic por_flag,
   input wire logic monitor_serial_pin_i,
   output logic monitor_serial_pin_o,
   output logic monitor_serial_pin_oe,
   output mmsc_pkg::mmsc_mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output mmsc_pkg::mmsc_exec_req_t exec_req,
   input wire logic exec_done,
   input wire logic [15:0] stack_ptr,
   input wire logic index_load,
   input wire logic [15:0] index_value,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic bulk_erase,
   output logic illegal_addr_reset,
   output logic security_bypassed
);
   import mmsc_pkg::*;

   function automatic logic is_flash(input logic [15:0] a);
      is_flash = (a >= FLASH_LO);
   endfunction

   // the eight code locations, which a bulk erase leaves blank
   function automatic logic is_sec(input logic [15:0] a);
      is_sec = (a >= MMSC_SEC_BASE) &&
               (a <= MMSC_SEC_BASE + 16'(MMSC_SEC_LEN - 1));
   endfunction

   logic rx_busy_q, rx_busy_d, rx_valid_q, rx_valid_d;
   logic [15:0] rx_cnt_q, rx_cnt_d;
   logic [3:0] rx_bit_q, rx_bit_d;
   logic [7:0] rx_sh_q, rx_sh_d;
   logic tx_busy_q, tx_busy_d, pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
   logic [15:0] tx_cnt_q, tx_cnt_d;
   logic [3:0] tx_bit_q, tx_bit_d;
   logic [9:0] tx_sh_q, tx_sh_d;
   mmsc_state_t st_q, st_d, after_q, after_d;
   logic [2:0] cnt_q, cnt_d;
   logic match_q, match_d, tx_go_q, tx_go_d, brk_q, brk_d;
   logic [15:0] index_q, index_d;
   logic [7:0] data_q, data_d, tx_byte_q, tx_byte_d, stored;
   mmsc_mem_req_t mem_q, mem_d;
   mmsc_exec_req_t exec_q, exec_d;
   logic bypass_q, bypass_d, erased_q, erased_d, illegal_q, illegal_d;
   logic por_seen_q, por_seen_d;
   logic [15:0] sp_inc;

   // stacked pc sits at MMSC_PC_HI_OFS/LO_OFS above sp; host edits it
   assign sp_inc = stack_ptr + MMSC_SP_READ_OFS;

   // receiver: mid-bit sampling; ignored while we drive the shared wire
   always_comb begin
      rx_busy_d = rx_busy_q;
      rx_cnt_d = rx_cnt_q;
      rx_bit_d = rx_bit_q;
      rx_sh_d = rx_sh_q;
      rx_valid_d = 1'b0;
      if (!rx_busy_q) begin
         if (!monitor_serial_pin_i && !tx_busy_q && !tx_go_q) begin
            rx_busy_d = 1'b1;
            rx_cnt_d = BIT_CYCLES >> 1;
            rx_bit_d = 4'h0;
         end
      end else if (rx_cnt_q != 16'h0000) begin
         rx_cnt_d = rx_cnt_q - 16'h0001;
      end else if (rx_bit_q == 4'h0) begin
         // glitch on the start bit aborts the frame
         rx_busy_d = !monitor_serial_pin_i;
         rx_bit_d = 4'h1;
         rx_cnt_d = BIT_CYCLES - 16'h0001;
      end else if (rx_bit_q < MMSC_FRAME_LAST) begin
         rx_sh_d = {monitor_serial_pin_i, rx_sh_q[7:1]};
         rx_bit_d = rx_bit_q + 4'h1;
         rx_cnt_d = BIT_CYCLES - 16'h0001;
      end else begin
         rx_busy_d = 1'b0;
         rx_valid_d = monitor_serial_pin_i; // framing error drops byte
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_busy_q <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_cnt_q <= 16'h0000;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
      end else begin
         rx_busy_q <= rx_busy_d;
         rx_valid_q <= rx_valid_d;
         rx_cnt_q <= rx_cnt_d;
         rx_bit_q <= rx_bit_d;
         rx_sh_q <= rx_sh_d;
      end
   end

   // transmitter: ten-bit frame, all zeros for a break
   always_comb begin
      tx_busy_d = tx_busy_q;
      tx_cnt_d = tx_cnt_q;
      tx_bit_d = tx_bit_q;
      tx_sh_d = tx_sh_q;
      pin_o_d = pin_o_q;
      pin_oe_d = pin_oe_q;
      if (!tx_busy_q) begin
         if (tx_go_q) begin
            tx_sh_d = brk_q ? 10'h000 : {1'b1, tx_byte_q, 1'b0};
            tx_busy_d = 1'b1;
            tx_bit_d = 4'h0;
            tx_cnt_d = BIT_CYCLES - 16'h0001;
            pin_o_d = 1'b0;
            pin_oe_d = 1'b1;
         end
      end else if (tx_cnt_q != 16'h0000) begin
         tx_cnt_d = tx_cnt_q - 16'h0001;
      end else if (tx_bit_q == MMSC_FRAME_LAST) begin
         tx_busy_d = 1'b0;
         pin_o_d = 1'b1;
         pin_oe_d = 1'b0; // release: the pull-up idles the line
      end else begin
         tx_sh_d = {1'b1, tx_sh_q[9:1]};
         pin_o_d = tx_sh_q[1];
         tx_bit_d = tx_bit_q + 4'h1;
         tx_cnt_d = BIT_CYCLES - 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_busy_q <= 1'b0;
         tx_cnt_q <= 16'h0000;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 10'h3FF;
         pin_o_q <= 1'b1;
         pin_oe_q <= 1'b0;
      end else begin
         tx_busy_q <= tx_busy_d;
         tx_cnt_q <= tx_cnt_d;
         tx_bit_q <= tx_bit_d;
         tx_sh_q <= tx_sh_d;
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   // main sequencer: entry, security, commands
   always_comb begin
      st_d = st_q;
      after_d = after_q;
      cnt_d = cnt_q;
      match_d = match_q;
      index_d = index_q;
      data_d = data_q;
      tx_go_d = 1'b0;
      tx_byte_d = tx_byte_q;
      brk_d = brk_q;
      mem_d = mem_q;
      exec_d = exec_q;
      stored = erased_q ? MMSC_SEC_BLANK : mem_rdata;
      case (st_q)
         S_ENT_INT: begin
            exec_d = '{valid: !exec_done, op: MMSC_EX_SOFT_INT};
            if (exec_done) st_d = S_ENT_PUSH;
         end
         S_ENT_PUSH: begin
            exec_d = '{valid: !exec_done, op: MMSC_EX_PUSH_HI};
            if (exec_done) begin
               // only a power-on reset asks for the code
               st_d = por_seen_q ? S_SEC_RX : S_BREAK;
               cnt_d = 3'h0;
               match_d = 1'b1;
            end
         end
         S_SEC_RX: if (rx_valid_q) begin
            data_d = rx_sh_q;
            mem_d = '{valid: 1'b1, write: 1'b0, wdata: 8'h00,
                      addr: MMSC_SEC_BASE + {13'h0000, cnt_q}};
            st_d = S_SEC_RD;
         end
         S_SEC_RD: if (mem_ack) begin
            mem_d.valid = 1'b0;
            match_d = match_q && (stored == data_q);
            cnt_d = cnt_q + 3'h1;
            st_d = (cnt_q == 3'(MMSC_SEC_LEN - 1)) ? S_SEC_CHK : S_SEC_RX;
         end
         S_SEC_CHK: begin
            if (match_q) begin
               mem_d = '{valid: 1'b1, write: 1'b1, addr: MMSC_SEC_FLAG_ADDR,
                         wdata: 8'(1 << MMSC_SEC_FLAG_BIT)};
               st_d = S_SEC_FLAG;
            end else begin
               st_d = S_BREAK; // stay in monitor, flash stays locked
            end
         end
         S_SEC_FLAG: if (mem_ack) begin
            mem_d.valid = 1'b0;
            st_d = S_BREAK;
         end
         S_BREAK: begin
            brk_d = 1'b1; // reached after the eighth byte, or straight after entry on a non-power-on reset
            tx_go_d = 1'b1;
            after_d = S_IDLE;
            st_d = S_TXW;
         end
         S_TXW: if (!tx_go_q && !tx_busy_q) begin
            brk_d = 1'b0;
            st_d = after_q;
         end
         S_IDLE: if (rx_valid_q) begin
            data_d = rx_sh_q;
            tx_byte_d = rx_sh_q;
            tx_go_d = 1'b1;
            after_d = S_DISP;
            st_d = S_TXW;
         end
         S_DISP: begin
            cnt_d = 3'h0;
            if (data_q == MMSC_OP_IDX_RD) begin
               st_d = S_RD_REQ;
            end else if (data_q == MMSC_OP_IDX_WR) begin
               st_d = S_WR_RX;
            end else if (data_q == MMSC_OP_READ_SP) begin
               tx_byte_d = sp_inc[15:8];
               tx_go_d = 1'b1;
               after_d = S_SP_LO;
               st_d = S_TXW;
            end else if (data_q == MMSC_OP_RUN) begin
               st_d = S_RUN_PULL;
            end else begin
               st_d = S_IDLE; // unknown opcode: echoed, then dropped
            end
         end
         S_RD_REQ: begin
            mem_d = '{valid: 1'b1, write: 1'b0, addr: index_q, wdata: 8'h00};
            st_d = S_RD_ACK;
         end
         S_RD_ACK: if (mem_ack) begin
            mem_d.valid = 1'b0;
            // a locked flash read hides even the blank code bytes
            if (is_flash(index_q) && !bypass_q) begin
               tx_byte_d = MMSC_INVALID_BYTE;
            end else if (erased_q && is_sec(index_q)) begin
               tx_byte_d = MMSC_SEC_BLANK;
            end else begin
               tx_byte_d = mem_rdata;
            end
            index_d = index_q + 16'h0001; // wraps over 64K
            cnt_d = cnt_q + 3'h1;
            tx_go_d = 1'b1;
            after_d = (cnt_q == 3'h1) ? S_IDLE : S_RD_REQ;
            st_d = S_TXW;
         end
         S_WR_RX: if (rx_valid_q) begin
            data_d = rx_sh_q;
            tx_byte_d = rx_sh_q;
            tx_go_d = 1'b1;
            after_d = S_WR_REQ;
            st_d = S_TXW;
         end
         S_WR_REQ: begin
            mem_d = '{valid: 1'b1, write: 1'b1, addr: index_q, wdata: data_q};
            st_d = S_WR_ACK;
         end
         S_WR_ACK: if (mem_ack) begin
            mem_d.valid = 1'b0;
            index_d = index_q + 16'h0001;
            st_d = S_IDLE;
         end
         S_SP_LO: begin
            tx_byte_d = sp_inc[7:0];
            tx_go_d = 1'b1;
            after_d = S_IDLE;
            st_d = S_TXW;
         end
         S_RUN_PULL: begin
            exec_d = '{valid: !exec_done, op: MMSC_EX_PULL_HI};
            if (exec_done) st_d = S_RUN_RET;
         end
         S_RUN_RET: begin
            exec_d = '{valid: !exec_done, op: MMSC_EX_RET_INT};
            if (exec_done) st_d = S_USER;
         end
         default: st_d = S_USER; // user program runs until next reset
      endcase
      if (index_load) index_d = index_value;
   end

   // sticky bypass and erase state; only a power-on reset clears it (por_seen_q is reloaded by every reset)
   always_comb begin
      por_seen_d = reset ? por_flag : por_seen_q;
      bypass_d = bypass_q || (st_q == S_SEC_CHK && match_q);
      if (reset && por_flag) bypass_d = 1'b0;
      erased_d = (erased_q || bulk_erase) && !(reset && por_flag);
      illegal_d = !reset && fetch_valid && is_flash(fetch_addr) &&
                  !bypass_q;
   end

   always_ff @(posedge ref_clk) begin
      por_seen_q <= por_seen_d;
      bypass_q <= bypass_d;
      erased_q <= erased_d;
      illegal_q <= illegal_d;
      if (reset) begin
         st_q <= S_ENT_INT;
         after_q <= S_IDLE;
         cnt_q <= 3'h0;
         match_q <= 1'b0;
         index_q <= 16'h0000;
         data_q <= 8'h00;
         tx_go_q <= 1'b0;
         tx_byte_q <= 8'h00;
         brk_q <= 1'b0;
         mem_q <= '0;
         exec_q <= '0;
      end else begin
         st_q <= st_d;
         after_q <= after_d;
         cnt_q <= cnt_d;
         match_q <= match_d;
         index_q <= index_d;
         data_q <= data_d;
         tx_go_q <= tx_go_d;
         tx_byte_q <= tx_byte_d;
         brk_q <= brk_d;
         mem_q <= mem_d;
         exec_q <= exec_d;
      end
   end

   assign monitor_serial_pin_o = pin_o_q;
   assign monitor_serial_pin_oe = pin_oe_q;
   assign mem_req = mem_q;
   assign exec_req = exec_q;
   assign illegal_addr_reset = illegal_q;
   assign security_bypassed = bypass_q;

   // helper: security bytes taken since reset
   logic [3:0] sec_n_q;
   always_ff @(posedge ref_clk) begin
      if (reset) sec_n_q <= 4'h0;
      else if (st_q == S_SEC_RX && rx_valid_q) sec_n_q <= sec_n_q + 4'h1;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_pull_done;
      exec_q.valid && exec_q.op == MMSC_EX_PULL_HI && exec_done;
   endsequence
   sequence s_ret_req;
      exec_q.valid && exec_q.op == MMSC_EX_RET_INT;
   endsequence
   // the request drops for one cycle between two instructions
   chk_run_order: assert property (s_pull_done |=>
      !exec_q.valid ##1 s_ret_req)
      else $error("run did not follow pull with return");
   chk_entry_order: assert property (exec_q.valid && exec_done &&
      exec_q.op == MMSC_EX_SOFT_INT |=> !exec_q.valid ##1
      (exec_q.valid && exec_q.op == MMSC_EX_PUSH_HI))
      else $error("entry did not push after interrupt");
   chk_sp_plus_one: assert property (st_q == S_DISP &&
      data_q == MMSC_OP_READ_SP |=> tx_go_q &&
      tx_byte_q == 8'(16'($past(stack_ptr) + 16'h0001) >> 8))
      else $error("stack pointer read not incremented");
   chk_echo_cmd: assert property (st_q == S_IDLE && rx_valid_q |=>
      tx_go_q && tx_byte_q == $past(rx_sh_q))
      else $error("command byte not echoed");
   chk_break_gate: assert property (tx_go_q && brk_q |->
      !por_seen_q || sec_n_q == 4'(MMSC_SEC_LEN))
      else $error("break sent before all security bytes");
   chk_bypass_cause: assert property ($rose(bypass_q) |->
      $past(st_q) == S_SEC_CHK && $past(match_q))
      else $error("bypass set without a full match");
   chk_bypass_hold: assert property (bypass_q |=> bypass_q)
      else $error("bypass lost without power-on reset");
   chk_invalid_read: assert property (st_q == S_RD_ACK && mem_ack &&
      !bypass_q && is_flash(index_q) |=> tx_go_q &&
      tx_byte_q == MMSC_INVALID_BYTE)
      else $error("secured flash read returned data");
   chk_illegal_fetch: assert property (fetch_valid && !bypass_q &&
      is_flash(fetch_addr) |=> illegal_q)
      else $error("secured flash fetch not trapped");
   chk_step_index: assert property (st_q == S_WR_ACK && mem_ack &&
      !index_load |=> index_q == 16'($past(index_q) + 16'h0001))
      else $error("index did not advance");
   chk_flag_write: assert property (st_q == S_SEC_CHK && match_q |=>
      mem_q.valid && mem_q.write && mem_q.addr == MMSC_SEC_FLAG_ADDR &&
      mem_q.wdata[MMSC_SEC_FLAG_BIT])
      else $error("security flag not written");
endmodule

`default_nettype wire

// ---- design/mmsc_pkg.sv ----
// shared constants and types for the monitor-mode command block
package mmsc_pkg;
   // command opcodes received on the monitor serial line
   localparam logic [7:0] MMSC_OP_IDX_WR = 8'h19;
   localparam logic [7:0] MMSC_OP_RUN = 8'h28;
   localparam logic [7:0] MMSC_OP_IDX_RD = 8'h1A;
   localparam logic [7:0] MMSC_OP_READ_SP = 8'h0C;
   // security bytes and the flag that records a good entry
   localparam int MMSC_SEC_LEN = 8;
   localparam logic [15:0] MMSC_SEC_BASE = 16'hFFF6;
   localparam logic [7:0] MMSC_SEC_BLANK = 8'hFF;
   localparam logic [15:0] MMSC_SEC_FLAG_ADDR = 16'h0040;
   localparam int MMSC_SEC_FLAG_BIT = 6;
   // returned for a protected flash read
   localparam logic [7:0] MMSC_INVALID_BYTE = 8'hAD;
   // stacked program counter bytes relative to the stack pointer
   localparam logic [15:0] MMSC_SP_READ_OFS = 16'h0001;
   localparam logic [15:0] MMSC_PC_HI_OFS = 16'h0005;
   localparam logic [15:0] MMSC_PC_LO_OFS = 16'h0006;
   // serial framing: clock cycles per bit and index of the last (stop) bit in a frame
   localparam logic [15:0] MMSC_BIT_CYCLES = 16'h0411;
   localparam logic [3:0] MMSC_FRAME_LAST = 4'h9;
   localparam logic [15:0] MMSC_FLASH_LO = 16'h8000;

   typedef enum logic [1:0] {
      MMSC_EX_SOFT_INT, MMSC_EX_PUSH_HI, MMSC_EX_PULL_HI, MMSC_EX_RET_INT
   } mmsc_exec_op_t;

   typedef struct packed {
      logic valid;
      mmsc_exec_op_t op;
   } mmsc_exec_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mmsc_mem_req_t;

   typedef enum logic [4:0] {
      S_ENT_INT, S_ENT_PUSH, S_SEC_RX, S_SEC_RD, S_SEC_CHK, S_SEC_FLAG,
      S_BREAK, S_TXW, S_IDLE, S_DISP, S_RD_REQ, S_RD_ACK, S_WR_RX,
      S_WR_REQ, S_WR_ACK, S_SP_LO, S_RUN_PULL, S_RUN_RET, S_USER
   } mmsc_state_t;
endpackage

// ---- testbench/mmsc_host.sv ----
// host-side model driving the single-wire monitor serial line
`timescale 1ns/1ps
`default_nettype none

module mmsc_host_model #(
   parameter int BITC = 8
) (
   input wire logic ref_clk,
   output logic host_drv
);
   // released line: the pull-up holds it high between frames
   initial host_drv = 1'b1;

   // one 8N1 frame, lsb first, after gap idle bit times
   task automatic send_byte(input logic [7:0] b, input int gap);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      repeat (gap * BITC) @(posedge ref_clk);
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         #1 host_drv = f[i];
         repeat (BITC - 1) @(posedge ref_clk);
      end
   endtask
endmodule

`default_nettype wire

// ---- testbench/tb_mmsc_monitor.sv ----
// self-checking bench for the monitor-mode command block
`timescale 1ns/1ps
`default_nettype none

module tb_mmsc_monitor;
   import mmsc_pkg::*;
   localparam int BITC = 8;
   logic ref_clk, reset, por_flag, dev_o, dev_oe, host_drv;
   logic mem_ack, exec_done, index_load, fetch_valid, bulk_erase;
   logic ill_rst, bypassed;
   logic [7:0] mem_rdata, d;
   logic [15:0] stack_ptr, index_value, fetch_addr, a, sp;
   mmsc_mem_req_t mem_req;
   mmsc_exec_req_t exec_req;
   logic [7:0] mem [0:65535];
   logic [15:0] exp_q[$];
   logic [15:0] exp_ex[$];
   logic [8:0] got;
   int fails, cmp_count, ill_cnt, mlat, xlat;
   // wire-AND of both drivers with a pull-up
   wire logic line = (dev_oe ? dev_o : 1'b1) & host_drv;

   mmsc_monitor #(.BIT_CYCLES(16'h0008)) mmsc_monitor_i (
      .ref_clk(ref_clk), .reset(reset), .por_flag(por_flag),
      .monitor_serial_pin_i(line), .monitor_serial_pin_o(dev_o),
      .monitor_serial_pin_oe(dev_oe), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .exec_req(exec_req),
      .exec_done(exec_done), .stack_ptr(stack_ptr),
      .index_load(index_load), .index_value(index_value),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .bulk_erase(bulk_erase), .illegal_addr_reset(ill_rst),
      .security_bypassed(bypassed)
   );
   mmsc_host_model #(.BITC(BITC)) mmsc_host_model_i (
      .ref_clk(ref_clk), .host_drv(host_drv)
   );

   always #2.5 ref_clk = ~ref_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // bounded wait until every noted frame and instruction was seen
   task automatic drain();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || exp_ex.size() != 0) && n < 5000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 5000) fails++;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   function automatic void note(input logic [7:0] b);
      exp_q.push_back({8'h01, b});
   endfunction

   // a command byte whose echo is expected
   task automatic cmd(input logic [7:0] b);
      note(b);
      mmsc_host_model_i.send_byte(b, 1);
   endtask

   task automatic idx_read(input logic [7:0] d0, input logic [7:0] d1);
      cmd(MMSC_OP_IDX_RD);
      note(d0);
      note(d1);
      drain();
   endtask

   task automatic idx(input logic [15:0] v);
      @(posedge ref_clk);
      #1 index_load = 1'b1;
      index_value = v;
      @(posedge ref_clk);
      #1 index_load = 1'b0;
   endtask

   task automatic fetch(input logic [15:0] v, input int n);
      ill_cnt = 0;
      @(posedge ref_clk);
      #1 fetch_valid = 1'b1;
      fetch_addr = v;
      @(posedge ref_clk);
      #1 fetch_valid = 1'b0;
      repeat (6) @(posedge ref_clk);
      check(16'(ill_cnt), 16'(n));
   endtask

   // entry always runs the two stacking instructions
   task automatic do_reset(input logic por);
      por_flag = por;
      reset = 1'b1;
      exp_ex.push_back(16'(MMSC_EX_SOFT_INT));
      exp_ex.push_back(16'(MMSC_EX_PUSH_HI));
      if (!por) exp_q.push_back(16'h0000);
      repeat (5) @(posedge ref_clk);
      #1 reset = 1'b0;
      drain();
   endtask

   // break is noted only ahead of the last byte, so an early one fails
   task automatic sec_entry(input logic good);
      for (int i = 0; i < 8; i++) begin
         if (i == 7) exp_q.push_back(16'h0000);
         d = mem[16'(MMSC_SEC_BASE + i)];
         if (!good && i == 3) d = d ^ 8'h5A;
         mmsc_host_model_i.send_byte(d, 2);
      end
      drain();
   endtask

   // memory answers after 1..3 cycles; idle data never holds still
   always begin
      @(posedge ref_clk);
      #1;
      if (mem_ack) mem_ack = 1'b0;
      else if (mem_req.valid === 1'b1) begin
         if (mlat == 0) begin
            mem_ack = 1'b1;
            mem_rdata = mem[mem_req.addr];
            if (mem_req.write) mem[mem_req.addr] = mem_req.wdata;
            mlat = $urandom_range(2, 0);
         end else mlat--;
      end else mem_rdata = ~mem_rdata;
   end

   // core: finishes each instruction slowly or promptly
   always begin
      @(posedge ref_clk);
      #1;
      if (exec_done) exec_done = 1'b0;
      else if (exec_req.valid === 1'b1) begin
         if (xlat == 0) begin
            exec_done = 1'b1;
            check({14'h0, exec_req.op},
               exp_ex.size() ? exp_ex.pop_front() : 16'hFFFF);
            xlat = $urandom_range(3, 0);
         end else xlat--;
      end
   end

   // frame watcher: start, 8 data bits, stop level; a break gives 0
   always begin
      @(posedge ref_clk);
      if (dev_oe === 1'b1 && line === 1'b0) begin
         repeat (BITC / 2) @(posedge ref_clk);
         for (int i = 0; i < 9; i++) begin
            repeat (BITC) @(posedge ref_clk);
            got[i] = line;
         end
         check({7'h0, got},
            exp_q.size() ? exp_q.pop_front() : 16'hFFFF);
         while (line !== 1'b1) @(posedge ref_clk);
      end
   end

   always @(posedge ref_clk) if (ill_rst === 1'b1) ill_cnt++;

   // the whole run is a few thousand cycles; this only cuts a hang
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      print_verdict();
   end

   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      por_flag = 1'b1;
      {mem_ack, exec_done, index_load, fetch_valid, bulk_erase} = '0;
      {index_value, fetch_addr, mem_rdata} = '0;
      {fails, cmp_count, ill_cnt, mlat, xlat} = '0;
      void'($urandom(32'h027a6fc3));
      stack_ptr = 16'($urandom);
      for (int i = 0; i < 65536; i++) mem[i] = 8'($urandom);
      mem[MMSC_SEC_FLAG_ADDR] = 8'h00;
      // wrong code: locked, flag untouched, flash hidden
      do_reset(1'b1);
      sec_entry(1'b0);
      check({15'h0, bypassed}, 16'h0000);
      check({8'h0, mem[MMSC_SEC_FLAG_ADDR]}, 16'h0000);
      idx(16'h9000);
      idx_read(MMSC_INVALID_BYTE, MMSC_INVALID_BYTE);
      fetch(16'h9000, 1);
      // retry with the right code
      do_reset(1'b1);
      sec_entry(1'b1);
      check({15'h0, bypassed}, 16'h0001);
      check({8'h0, mem[MMSC_SEC_FLAG_ADDR]}, 16'h0040);
      // back-to-back indexed accesses walk forward
      a = 16'h8000 | 16'($urandom_range(16'h3FFF, 0));
      idx(a);
      idx_read(mem[a], mem[16'(a + 1)]);
      idx_read(mem[16'(a + 2)], mem[16'(a + 3)]);
      d = 8'($urandom);
      cmd(MMSC_OP_IDX_WR);
      drain();
      cmd(d);
      drain();
      for (int n = 0; n < 100 && mem[16'(a + 4)] !== d; n++)
         @(posedge ref_clk);
      check({8'h0, mem[16'(a + 4)]}, {8'h0, d});
      fetch(a, 0);
      // an unknown opcode is echoed and then ignored
      cmd(8'h5A);
      drain();
      sp = stack_ptr + MMSC_SP_READ_OFS;
      cmd(MMSC_OP_READ_SP);
      note(sp[15:8]);
      note(sp[7:0]);
      drain();
      // warm reset keeps the bypass and skips code entry
      do_reset(1'b0);
      check({15'h0, bypassed}, 16'h0001);
      // erased code locations read blank
      @(posedge ref_clk);
      #1 bulk_erase = 1'b1;
      @(posedge ref_clk);
      #1 bulk_erase = 1'b0;
      idx(MMSC_SEC_BASE);
      idx_read(MMSC_SEC_BLANK, MMSC_SEC_BLANK);
      cmd(MMSC_OP_RUN);
      exp_ex.push_back(16'(MMSC_EX_PULL_HI));
      exp_ex.push_back(16'(MMSC_EX_RET_INT));
      drain();
      print_verdict();
   end
endmodule

`default_nettype wire
